// File: entry_store.sv
`timescale 1ns/1ps
`default_nettype none
// data halves of the unified buffer; read data registered
module entry_store #(
    parameter int W     = 33,
    parameter int DEPTH = 64
) (
    input  wire logic   clk,
    entry_store_if.store port
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (port.we) begin
            mem[port.waddr] <= port.wdata;
        end
        port.rdata <= mem[port.raddr];
    end
endmodule
`default_nettype wire

// File: entry_store_if.sv
`timescale 1ns/1ps
`default_nettype none
interface entry_store_if #(
    parameter int W     = 33,
    parameter int DEPTH = 64,
    parameter int AW    = 6
);
    logic          we;
    logic [AW-1:0] waddr;
    logic [W-1:0]  wdata;
    logic [AW-1:0] raddr;
    logic [W-1:0]  rdata;
    modport user  (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// File: mmu_access_protection.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// (RQ1) user load/store, zone 00: data-storage fault
// (RQ2) user store, no write permit, zone not 11
// (RQ3) privileged store, no write permit, zone not 10/11
// (RQ4) user fetch, zone 00: instruction-storage fault
// (RQ5) no run permit faults unless zone overrides
// (RQ6) guarded page execution always faults
// (RQ7) instruction fault reported at execution only
// (RQ8) data access without valid match: data miss
// (RQ9) fetch without valid match: instruction miss
// (RQ10) process tag must match; tag 00 global
// (RQ11) privileged loads always permitted
// (RQ12) 32-bit zone register, sixteen 2-bit fields
// (RQ13) entry zone index selects zone field
// (RQ14) unimplemented zones read as 11
// (RQ15) 64 entries addressed by entry index
// (RQ16) tag, data, extended halves accessed separately
// (RQ17) 64-bit configuration moves whole entry
// (RQ18) search write loads matching index
// (RQ19) invalid entries never hit
// (RQ20) parity error on lookup gives miss
// (RQ21) process id 00 hits only global entries
// (RQ22) data side wins buffer over fetch side
// (RQ23) any fault clears translation enable
// (RQ24) miss reported before protection fault
// (RQ25) translation off: no checks, no faults
module mmu_access_protection #(
    parameter int ZONE_COUNT = 16,
    parameter bit PARITY_EN  = 1'b0,
    parameter bit EXT_EN     = 1'b0,
    parameter bit FULL_ENTRY = 1'b0,
    parameter int EXT_W      = 8
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        data_req,
    input  wire logic        data_store,
    input  wire logic [31:0] data_addr,
    input  wire logic        fetch_req,
    input  wire logic [31:0] fetch_addr,
    input  wire logic        exec_valid,
    input  wire logic        exec_prot_flag,
    input  wire logic        sr_write,
    input  wire logic        sr_read,
    input  wire logic [2:0]  sr_sel,
    input  wire logic [63:0] sr_wdata,
    output logic             data_done,
    output logic             data_tlb_miss,
    output logic             data_storage_fault,
    output logic [21:0]      data_phys_page,
    output logic             fetch_done,
    output logic             fetch_tlb_miss,
    output logic             fetch_prot_flag,
    output logic             fetch_pending,
    output logic             instruction_storage_fault,
    output logic [63:0]      sr_rdata,
    output logic             sr_rvalid,
    output logic             virtual_translation_on,
    output logic             user_mode
);
    localparam int IW = mmu_prot_pkg::IDX_W;
    localparam int PW = mmu_prot_pkg::PID_W;
    localparam int EW = mmu_prot_pkg::EPN_W;

    if (ZONE_COUNT < 1 || ZONE_COUNT > mmu_prot_pkg::ZONES_MAX) begin : g_bad_zones
        $error("ZONE_COUNT must lie in 1..16");
    end
    if (EXT_W < 1 || EXT_W > 32) begin : g_bad_ext
        $error("EXT_W must lie in 1..32");
    end

    // software-visible state
    logic [1:0]        state_reg;
    logic [PW-1:0]     pid_reg;
    logic [31:0]       zone_override_reg;
    logic              index_miss_reg;
    logic [IW-1:0]     index_reg;
    logic [EW-1:0]     epn_reg   [mmu_prot_pkg::ENTRIES];
    logic [PW-1:0]     tid_reg   [mmu_prot_pkg::ENTRIES];
    logic              valid_reg [mmu_prot_pkg::ENTRIES];
    logic [EXT_W-1:0]  ext_reg   [mmu_prot_pkg::ENTRIES];

    // fetch parked behind a data access
    logic              park_reg;
    logic [31:0]       park_addr_reg;

    // stage 1: lookup done, data half being read
    logic              s1_valid_reg;
    logic              s1_data_reg;
    logic              s1_store_reg;
    logic              s1_check_reg;
    logic              s1_user_reg;
    logic              s1_hit_reg;
    logic              s1_rd_reg;
    logic [2:0]        s1_sel_reg;
    logic [IW-1:0]     s1_idx_reg;

    // fully associative compare; lowest index wins a multiple hit
    function automatic logic [IW:0] lookup(input logic [31:0] ea, input logic [PW-1:0] current_process_id);
        logic [IW:0] r;
        r = '0;
        for (int i = mmu_prot_pkg::ENTRIES - 1; i >= 0; i--) begin
            if (valid_reg[i] // RQ19
                && epn_reg[i] == ea[31:mmu_prot_pkg::TAG_EPN_LSB]
                && (tid_reg[i] == mmu_prot_pkg::TID_GLOBAL || tid_reg[i] == current_process_id)) begin // RQ10 RQ21
                r = {1'b1, IW'(i)};
            end
        end
        return r;
    endfunction

    // arbitration: data always served first, fetch waits for a cycle with no data request
    wire         vm_on       = state_reg[mmu_prot_pkg::VM_BIT];
    wire         serve_fetch = !data_req && (park_reg || fetch_req); // RQ22
    wire         park_next   = data_req && (fetch_req || park_reg);
    wire [31:0]  fetch_ea    = park_reg ? park_addr_reg : fetch_addr;
    wire         s0_valid    = data_req || serve_fetch;
    wire [31:0]  s0_ea       = data_req ? data_addr : fetch_ea;
    wire [IW:0]  s0_look     = lookup(s0_ea, pid_reg);
    wire [IW:0]  search_look = lookup(sr_wdata[31:0], pid_reg); // RQ18
    wire         wr_any      = sr_write;
    wire         wr_msr      = wr_any && sr_sel == mmu_prot_pkg::SEL_MACHINE_STATE;
    wire         wr_pid      = wr_any && sr_sel == mmu_prot_pkg::SEL_PROCESS_ID;
    wire         wr_zone     = wr_any && sr_sel == mmu_prot_pkg::SEL_ZONE_OVERRIDE;
    wire         wr_index    = wr_any && sr_sel == mmu_prot_pkg::SEL_ENTRY_INDEX;
    wire         wr_search   = wr_any && sr_sel == mmu_prot_pkg::SEL_ENTRY_SEARCH;
    wire         wr_tag      = wr_any && sr_sel == mmu_prot_pkg::SEL_TAG_HALF;
    wire         wr_data     = wr_any && sr_sel == mmu_prot_pkg::SEL_DATA_HALF;
    wire         wr_ext      = wr_any && sr_sel == mmu_prot_pkg::SEL_EXTENDED && EXT_EN;
    // whole-entry write: upper word of a tag write carries the data half
    wire         wr_whole    = wr_tag && FULL_ENTRY; // RQ17
    wire [31:0]  data_word   = wr_whole ? sr_wdata[63:32] : sr_wdata[31:0];
    wire         data_par    = PARITY_EN ? ^data_word : 1'b0; // RQ20

    entry_store_if #(.W(33), .DEPTH(mmu_prot_pkg::ENTRIES), .AW(IW)) store_bus ();

    // lookups own the read port; software reads only while no access is in flight
    assign store_bus.we    = wr_data || wr_whole; // RQ16
    assign store_bus.waddr = index_reg; // RQ15
    assign store_bus.wdata = {data_par, data_word};
    assign store_bus.raddr = s0_valid ? s0_look[IW-1:0] : index_reg;

    entry_store #(.W(33), .DEPTH(mmu_prot_pkg::ENTRIES)) store_u (
        .clk  (clk),
        .port (store_bus.store)
    );

    // stage 2 decode from the data half
    wire [31:0]  dh         = store_bus.rdata[31:0];
    wire         par_bad    = PARITY_EN && (^store_bus.rdata != 1'b0); // RQ20
    wire [3:0]   zone_idx   = dh[mmu_prot_pkg::ZONE_LSB +: 4]; // RQ13
    wire [1:0]   zone_field = zone_override_reg[31 - 2 * zone_idx -: 2]; // RQ12
    wire [1:0]   zone       = (zone_idx < ZONE_COUNT) ? zone_field
                                                      : mmu_prot_pkg::ZONE_FULL_OVR; // RQ14
    wire         z_none     = zone == mmu_prot_pkg::ZONE_NO_ACCESS;
    wire         z_full     = zone == mmu_prot_pkg::ZONE_FULL_OVR;
    wire         z_priv     = zone == mmu_prot_pkg::ZONE_PRIV_OVR || z_full;
    wire         ovr        = s1_user_reg ? z_full : z_priv;
    wire         miss       = s1_check_reg && (!s1_hit_reg || par_bad); // RQ8 RQ9 RQ20 RQ25
    // only stores are checked in privileged mode, so privileged loads pass
    wire         dsi_user   = s1_user_reg && z_none; // RQ1 RQ11
    wire         dsi_wr     = s1_store_reg && !dh[mmu_prot_pkg::WR_BIT] && !ovr; // RQ2 RQ3
    wire         dsi        = s1_check_reg && !miss && (dsi_user || dsi_wr); // RQ24
    wire         xf_user    = s1_user_reg && z_none; // RQ4
    wire         xf_run     = !dh[mmu_prot_pkg::RUN_BIT] && !ovr; // RQ5
    wire         xf_g       = dh[mmu_prot_pkg::GUARD_BIT]; // RQ6
    wire         xf_pend    = s1_check_reg && !miss && (xf_user || xf_run || xf_g); // RQ24
    wire         d_fin      = s1_valid_reg && s1_data_reg;
    wire         f_fin      = s1_valid_reg && !s1_data_reg;
    wire         xf_now     = exec_valid && exec_prot_flag && vm_on; // RQ7
    wire         fault      = (d_fin && (miss || dsi)) || (f_fin && miss) || xf_now;

    logic [63:0] rd_word;
    always_comb begin
        rd_word = '0;
        unique case (mmu_prot_pkg::sr_sel_e'(s1_sel_reg))
            mmu_prot_pkg::SEL_MACHINE_STATE: rd_word[1:0] = state_reg;
            mmu_prot_pkg::SEL_PROCESS_ID:    rd_word[PW-1:0] = pid_reg;
            mmu_prot_pkg::SEL_ZONE_OVERRIDE: rd_word[31:0] = zone_override_reg;
            mmu_prot_pkg::SEL_ENTRY_INDEX: begin
                rd_word[mmu_prot_pkg::INDEX_MISS_BIT] = index_miss_reg;
                rd_word[IW-1:0] = index_reg;
            end
            mmu_prot_pkg::SEL_ENTRY_SEARCH: rd_word = '0;
            mmu_prot_pkg::SEL_TAG_HALF: begin
                rd_word[31:mmu_prot_pkg::TAG_EPN_LSB] = epn_reg[s1_idx_reg];
                rd_word[mmu_prot_pkg::TAG_VALID_BIT] = valid_reg[s1_idx_reg];
                if (FULL_ENTRY) begin
                    rd_word[63:32] = dh; // RQ17
                end
            end
            mmu_prot_pkg::SEL_DATA_HALF: rd_word[31:0] = dh;
            mmu_prot_pkg::SEL_EXTENDED: begin
                if (EXT_EN) begin
                    rd_word[EXT_W-1:0] = ext_reg[s1_idx_reg]; // RQ16
                end
            end
        endcase
    end

    // machine state: a fault wins over a software write in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= mmu_prot_pkg::STAT_RESET;
        end else if (fault) begin
            state_reg <= 2'h0; // RQ23
        end else if (wr_msr) begin
            state_reg <= sr_wdata[1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pid_reg           <= mmu_prot_pkg::PID_RESET;
            zone_override_reg <= mmu_prot_pkg::ZONE_RESET;
            index_miss_reg    <= 1'b0;
            index_reg         <= '0;
        end else begin
            if (wr_pid) begin
                pid_reg <= sr_wdata[PW-1:0];
            end
            if (wr_zone) begin
                zone_override_reg <= sr_wdata[31:0];
            end
            if (wr_index) begin
                index_miss_reg <= 1'b0;
                index_reg      <= sr_wdata[IW-1:0];
            end else if (wr_search) begin
                index_miss_reg <= !search_look[IW]; // RQ18
                index_reg      <= search_look[IW-1:0];
            end
        end
    end

    // tag halves; the process tag is taken from the current id on write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < mmu_prot_pkg::ENTRIES; i++) begin
                epn_reg[i]   <= '0;
                tid_reg[i]   <= '0;
                valid_reg[i] <= 1'b0;
                ext_reg[i]   <= '0;
            end
        end else begin
            if (wr_tag) begin
                epn_reg[index_reg]   <= sr_wdata[31:mmu_prot_pkg::TAG_EPN_LSB];
                tid_reg[index_reg]   <= pid_reg;
                valid_reg[index_reg] <= sr_wdata[mmu_prot_pkg::TAG_VALID_BIT]; // RQ19
            end
            if (wr_ext) begin
                ext_reg[index_reg] <= sr_wdata[EXT_W-1:0]; // RQ16
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            park_reg      <= 1'b0;
            park_addr_reg <= '0;
            s1_valid_reg  <= 1'b0;
            s1_data_reg   <= 1'b0;
            s1_store_reg  <= 1'b0;
            s1_check_reg  <= 1'b0;
            s1_user_reg   <= 1'b0;
            s1_hit_reg    <= 1'b0;
            s1_rd_reg     <= 1'b0;
            s1_sel_reg    <= '0;
            s1_idx_reg    <= '0;
        end else begin
            park_reg <= park_next; // RQ22
            if (data_req && fetch_req) begin
                park_addr_reg <= fetch_addr;
            end
            s1_valid_reg <= s0_valid;
            s1_data_reg  <= data_req;
            s1_store_reg <= data_req && data_store;
            s1_check_reg <= s0_valid && vm_on; // RQ25
            s1_user_reg  <= state_reg[mmu_prot_pkg::USER_BIT];
            s1_hit_reg   <= s0_look[IW];
            s1_rd_reg    <= sr_read;
            s1_sel_reg   <= sr_sel;
            s1_idx_reg   <= index_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_done                 <= 1'b0;
            data_tlb_miss             <= 1'b0;
            data_storage_fault        <= 1'b0;
            data_phys_page            <= '0;
            fetch_done                <= 1'b0;
            fetch_tlb_miss            <= 1'b0;
            fetch_prot_flag           <= 1'b0;
            instruction_storage_fault <= 1'b0;
            sr_rdata                  <= '0;
            sr_rvalid                 <= 1'b0;
        end else begin
            data_done                 <= d_fin;
            data_tlb_miss             <= d_fin && miss; // RQ8
            data_storage_fault        <= d_fin && dsi; // RQ1 RQ2 RQ3
            data_phys_page            <= dh[31:mmu_prot_pkg::RPN_LSB];
            fetch_done                <= f_fin;
            fetch_tlb_miss            <= f_fin && miss; // RQ9
            // carried with the instruction, reported only when it executes
            fetch_prot_flag           <= f_fin && xf_pend; // RQ7
            instruction_storage_fault <= xf_now; // RQ7
            sr_rdata                  <= s1_rd_reg ? rd_word : 64'h0;
            sr_rvalid                 <= s1_rd_reg;
        end
    end

    assign fetch_pending          = park_reg;
    assign virtual_translation_on = state_reg[mmu_prot_pkg::VM_BIT];
    assign user_mode              = state_reg[mmu_prot_pkg::USER_BIT];
endmodule
`default_nettype wire

// File: mmu_access_protection_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mmu_prot_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic data_req,
    input wire logic data_store,
    input wire logic fetch_req,
    input wire logic exec_valid,
    input wire logic exec_prot_flag,
    input wire logic data_done,
    input wire logic data_tlb_miss,
    input wire logic data_storage_fault,
    input wire logic fetch_done,
    input wire logic fetch_tlb_miss,
    input wire logic fetch_pending,
    input wire logic instruction_storage_fault,
    input wire logic virtual_translation_on,
    input wire logic user_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_data_lat; data_req |-> ##2 data_done; endproperty
    a_data_lat: assert property (p_data_lat) else $error("data result late");
    property p_park; fetch_req && data_req && !fetch_pending |=> fetch_pending ##2 fetch_done;
    endproperty
    a_park: assert property (p_park) else $error("parked fetch lost");
    property p_off;
        data_req && !virtual_translation_on |-> ##2 !data_tlb_miss && !data_storage_fault;
    endproperty
    a_off: assert property (p_off) else $error("fault with translation off");
    property p_priv_load; data_req && !data_store && !user_mode |-> ##2 !data_storage_fault;
    endproperty
    a_priv_load: assert property (p_priv_load) else $error("privileged load refused");
    property p_isf;
        exec_valid && exec_prot_flag && virtual_translation_on
            |=> instruction_storage_fault && !virtual_translation_on;
    endproperty
    a_isf: assert property (p_isf) else $error("execute fault missing");
    property p_isf_cause;
        instruction_storage_fault |-> $past(exec_valid) && $past(exec_prot_flag);
    endproperty
    a_isf_cause: assert property (p_isf_cause) else $error("execute fault uncaused");
    property p_clear;
        data_tlb_miss || data_storage_fault || fetch_tlb_miss
            |-> !virtual_translation_on && !user_mode;
    endproperty
    a_clear: assert property (p_clear) else $error("machine state kept");
    property p_miss_first; data_tlb_miss |-> data_done && !data_storage_fault; endproperty
    a_miss_first: assert property (p_miss_first) else $error("miss with fault");
endmodule
bind mmu_access_protection mmu_prot_checker u_mmu_prot_checker (
    .clk, .rst, .data_req, .data_store, .fetch_req, .exec_valid, .exec_prot_flag,
    .data_done, .data_tlb_miss, .data_storage_fault, .fetch_done, .fetch_tlb_miss,
    .fetch_pending, .instruction_storage_fault, .virtual_translation_on, .user_mode
);
`default_nettype wire

// File: mmu_prot_pkg.sv
`default_nettype none
package mmu_prot_pkg;
    localparam int ENTRIES        = 64;
    localparam int IDX_W          = 6;
    localparam int EPN_W          = 22;
    localparam int PID_W          = 8;
    localparam int ZONES_MAX      = 16;
    localparam int DATA_W         = 32;
    // machine state word
    localparam int VM_BIT         = 0;
    localparam int USER_BIT       = 1;
    // tag half layout
    localparam int TAG_EPN_LSB    = 10;
    localparam int TAG_VALID_BIT  = 7;
    // data half layout
    localparam int RPN_LSB        = 10;
    localparam int RUN_BIT        = 9;
    localparam int WR_BIT         = 8;
    localparam int ZONE_LSB       = 4;
    localparam int GUARD_BIT      = 0;
    // entry index word
    localparam int INDEX_MISS_BIT = 31;
    // reset values and the global process tag
    localparam logic [1:0]       STAT_RESET = 2'h0;
    localparam logic [PID_W-1:0] PID_RESET  = 8'h00;
    localparam logic [31:0]      ZONE_RESET = 32'h0000_0000;
    localparam logic [PID_W-1:0] TID_GLOBAL = 8'h00;
    // zone override codes
    localparam logic [1:0] ZONE_NO_ACCESS = 2'h0;
    localparam logic [1:0] ZONE_PRIV_OVR  = 2'h2;
    localparam logic [1:0] ZONE_FULL_OVR  = 2'h3;
    // access path latency: request edge to result, in cycles
    localparam int RESULT_LATENCY = 2;

    typedef enum logic [2:0] {
        SEL_MACHINE_STATE = 3'h0,
        SEL_PROCESS_ID    = 3'h1,
        SEL_ZONE_OVERRIDE = 3'h2,
        SEL_ENTRY_INDEX   = 3'h3,
        SEL_ENTRY_SEARCH  = 3'h4,
        SEL_TAG_HALF      = 3'h5,
        SEL_DATA_HALF     = 3'h6,
        SEL_EXTENDED      = 3'h7
    } sr_sel_e;
endpackage
`default_nettype wire

// File: pipeline_model.sv
`timescale 1ns/1ps
`default_nettype none
module pipeline_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic fetch_done,
    input  wire logic fetch_prot_flag,
    input  wire logic exec_cmd,
    output logic      exec_valid,
    output logic      exec_prot_flag
);
    logic held_flag = 1'b0;
    // a later fetch overwrites the slot: that instruction is discarded unexecuted
    always @(negedge clk) begin
        if (rst) begin
            held_flag <= 1'b0;
        end else if (fetch_done) begin
            held_flag <= fetch_prot_flag;
        end
    end
    logic valid_q = 1'b0;
    logic flag_q = 1'b0;
    // flag is meaningless outside a valid cycle, so it toggles there
    always @(negedge clk) begin
        valid_q <= exec_cmd;
        flag_q <= exec_cmd ? held_flag : ~flag_q;
    end
    assign exec_valid = valid_q;
    assign exec_prot_flag = flag_q;
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        data_req = 1'b0;
    logic        data_store = 1'b0;
    logic [31:0] data_addr = 32'h0;
    logic        fetch_req = 1'b0;
    logic [31:0] fetch_addr = 32'h0;
    logic        sr_write = 1'b0;
    logic        sr_read = 1'b0;
    logic [2:0]  sr_sel = 3'h0;
    logic [63:0] sr_wdata = 64'h0;
    logic        exec_cmd = 1'b0;
    logic        exec_valid, exec_prot_flag, data_done, data_tlb_miss, data_storage_fault;
    logic        fetch_done, fetch_tlb_miss, fetch_prot_flag, fetch_pending, user_mode;
    logic        instruction_storage_fault, sr_rvalid, virtual_translation_on, e;
    logic [21:0] data_phys_page;
    logic [63:0] sr_rdata;
    logic [31:0] d_page;
    int          fails = 0;
    int          n_checks = 0;

    always #4 clk = ~clk;

    // fewer zones than fields so unimplemented zones are reachable
    mmu_access_protection #(.ZONE_COUNT(12)) u_mmu_access_protection (
        .clk, .rst, .data_req, .data_store, .data_addr, .fetch_req, .fetch_addr, .exec_valid,
        .exec_prot_flag, .sr_write, .sr_read, .sr_sel, .sr_wdata, .data_done, .data_tlb_miss,
        .data_storage_fault, .data_phys_page, .fetch_done, .fetch_tlb_miss, .fetch_prot_flag,
        .fetch_pending, .instruction_storage_fault, .sr_rdata, .sr_rvalid,
        .virtual_translation_on, .user_mode
    );
    pipeline_model u_pipeline_model (
        .clk, .rst, .fetch_done, .fetch_prot_flag, .exec_cmd, .exec_valid, .exec_prot_flag
    );

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic sr_wr(input logic [2:0] s, input logic [31:0] d);
        @(negedge clk);
        sr_sel = s;
        sr_wdata = {32'h0, d};
        sr_write = 1'b1;
        @(negedge clk);
        sr_write = 1'b0;
    endtask
    task automatic sr_rd(input logic [2:0] s, input logic [63:0] m, input logic [63:0] x);
        @(negedge clk);
        sr_sel = s;
        sr_read = 1'b1;
        @(negedge clk);
        sr_read = 1'b0;
        repeat (4) if (sr_rvalid !== 1'b1) @(negedge clk);
        chk({63'h0, sr_rvalid}, 64'h1);
        chk(sr_rdata & m, x);
    endtask
    // k selects the fetch path; result is {done, miss, fault or flag}
    task automatic acc(input logic k, input logic st, input logic [21:0] p,
                       input logic em, input logic ef);
        @(negedge clk);
        data_req = !k;
        fetch_req = k;
        data_store = st;
        data_addr = {p, 10'h0};
        fetch_addr = {p, 10'h0};
        @(negedge clk);
        data_req = 1'b0;
        fetch_req = 1'b0;
        data_addr = ~data_addr;
        fetch_addr = ~fetch_addr;
        repeat (4) if ((k ? fetch_done : data_done) !== 1'b1) @(negedge clk);
        chk(64'(k ? {fetch_done, fetch_tlb_miss, fetch_prot_flag}
                  : {data_done, data_tlb_miss, data_storage_fault}), {61'h0, 1'b1, em, ef});
    endtask
    task automatic exe(input logic f);
        @(negedge clk);
        exec_cmd <= 1'b1;
        @(negedge clk);
        exec_cmd <= 1'b0;
        repeat (4) if (instruction_storage_fault !== 1'b1) @(negedge clk);
        chk({62'h0, instruction_storage_fault, virtual_translation_on}, {62'h0, f, !f});
    endtask
    task automatic mode(input logic u);
        sr_wr(mmu_prot_pkg::SEL_MACHINE_STATE, {30'h0, u, 1'b1});
    endtask
    task automatic zone(input logic [31:0] z);
        sr_wr(mmu_prot_pkg::SEL_ZONE_OVERRIDE, z);
    endtask
    task automatic current_process_id(input logic [31:0] d);
        sr_wr(mmu_prot_pkg::SEL_PROCESS_ID, d);
    endtask
    task automatic ent(input logic [5:0] i, input logic [21:0] p, input logic v,
                       input logic [31:0] d);
        sr_wr(mmu_prot_pkg::SEL_ENTRY_INDEX, {26'h0, i});
        sr_wr(mmu_prot_pkg::SEL_TAG_HALF, {p, 2'h0, v, 7'h00});
        sr_wr(mmu_prot_pkg::SEL_DATA_HALF, d);
    endtask
    function automatic logic [31:0] dw(input logic [21:0] r, input logic x, input logic w,
                                       input logic [3:0] z, input logic g);
        return {r, x, w, z, 3'h0, g};
    endfunction

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        sr_rd(mmu_prot_pkg::SEL_ZONE_OVERRIDE, '1, 64'h0);
        sr_rd(mmu_prot_pkg::SEL_ENTRY_INDEX, '1, 64'h0);
        acc(1'b0, 1'b1, 22'h9, 1'b0, 1'b0);
        zone(32'h1234_5678);
        sr_rd(mmu_prot_pkg::SEL_ZONE_OVERRIDE, 64'hffff_ff00, 64'h1234_5600);
        current_process_id(32'h5);
        ent(6'h00, 22'h1, 1'b1, dw(22'h101, 1'b1, 1'b0, 4'h1, 1'b0));
        current_process_id(32'h0);
        ent(6'h01, 22'h2, 1'b1, dw(22'h102, 1'b0, 1'b0, 4'h1, 1'b0));
        ent(6'h02, 22'h3, 1'b1, dw(22'h103, 1'b1, 1'b1, 4'h5, 1'b1));
        d_page = dw(22'h104, 1'b1, 1'b0, 4'hd, 1'b0);
        ent(6'h3f, 22'h4, 1'b1, d_page);
        sr_rd(mmu_prot_pkg::SEL_DATA_HALF, 64'hffff_fff1, {32'h0, d_page});
        sr_wr(mmu_prot_pkg::SEL_ENTRY_SEARCH, 32'h0000_0800);
        sr_rd(mmu_prot_pkg::SEL_ENTRY_INDEX, 64'h8000_003f, 64'h1);
        sr_wr(mmu_prot_pkg::SEL_ENTRY_SEARCH, 32'h0000_2400);
        sr_rd(mmu_prot_pkg::SEL_ENTRY_INDEX, 64'h8000_0000, 64'h8000_0000);
        current_process_id(32'h5);
        for (int zc = 0; zc < 4; zc++) begin
            for (int u = 0; u < 2; u++) begin
                for (int st = 0; st < 2; st++) begin
                    zone(32'(zc) << 28);
                    mode(u[0]);
                    e = u ? (zc == 0 || (st == 1 && zc != 3)) : (st == 1 && zc < 2);
                    acc(1'b0, st[0], 22'h1, 1'b0, e);
                end
                mode(u[0]);
                acc(1'b1, 1'b0, 22'h2, 1'b0, u ? zc != 3 : zc < 2);
                acc(1'b1, 1'b0, 22'h1, 1'b0, u == 1 && zc == 0);
            end
        end
        zone(32'hffff_ffff);
        for (int u = 0; u < 2; u++) begin
            mode(u[0]);
            acc(1'b1, 1'b0, 22'h3, 1'b0, 1'b1);
        end
        mode(1'b1);
        zone(32'hffcf_ffff);
        acc(1'b0, 1'b0, 22'h3, 1'b0, 1'b1);
        chk({63'h0, virtual_translation_on}, 64'h0);
        mode(1'b1);
        zone(32'h0000_0000);
        acc(1'b0, 1'b1, 22'h4, 1'b0, 1'b0);
        chk({42'h0, data_phys_page}, 64'h104);
        mode(1'b0);
        acc(1'b1, 1'b0, 22'h2, 1'b0, 1'b1);
        acc(1'b1, 1'b0, 22'h1, 1'b0, 1'b0);
        exe(1'b0);
        acc(1'b1, 1'b0, 22'h2, 1'b0, 1'b1);
        exe(1'b1);
        mode(1'b1);
        acc(1'b0, 1'b0, 22'h9, 1'b1, 1'b0);
        chk({63'h0, user_mode}, 64'h0);
        mode(1'b1);
        acc(1'b1, 1'b0, 22'h9, 1'b1, 1'b0);
        current_process_id(32'h6);
        mode(1'b0);
        acc(1'b0, 1'b0, 22'h1, 1'b1, 1'b0);
        mode(1'b0);
        acc(1'b0, 1'b0, 22'h2, 1'b0, 1'b0);
        current_process_id(32'h0);
        acc(1'b0, 1'b0, 22'h1, 1'b1, 1'b0);
        current_process_id(32'h5);
        ent(6'h00, 22'h1, 1'b0, 32'h0);
        mode(1'b1);
        acc(1'b0, 1'b1, 22'h1, 1'b1, 1'b0);
        mode(1'b0);
        @(negedge clk);
        data_req = 1'b1;
        fetch_req = 1'b1;
        data_addr = 32'h0000_0800;
        fetch_addr = 32'h0000_0c00;
        @(negedge clk);
        data_req = 1'b0;
        fetch_req = 1'b0;
        chk({63'h0, fetch_pending}, 64'h1);
        repeat (5) if (fetch_done !== 1'b1) @(negedge clk);
        chk({63'h0, fetch_done}, 64'h1);
        report_and_stop();
    end

    // the sequence needs a few hundred cycles; allow ample margin
    initial begin
        #(20000 * 8);
        fails++;
        $display("mismatch at %0t: run timed out", $time);
        report_and_stop();
    end
endmodule
`default_nettype wire
